// ---- design/smc_pkg.sv ----
// Purpose: Shared constants and types for the SAR conversion control.
// Assumes: 50 MHz system clock.
// Notes: Times are in ns; cycle counts are derived from them.
`default_nettype none
package smc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACQ_TIME_NS = 250;
  localparam int WAKE_TIME_NS = 200;
  localparam int CAL_IDLE_NS = 1000000;
  localparam logic [3:0] ACQ_CYCLES =
    4'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WAKE_CYCLES =
    4'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CAL_IDLE_CYCLES = CAL_IDLE_NS / CLK_PERIOD_NS;
  // Cycles per bit trial; the worst case per mode fits its sample rate
  localparam logic [3:0] STEP_WARP = 4'h2;
  localparam logic [3:0] STEP_NORMAL = 4'h3;
  localparam logic [3:0] STEP_IMPULSE = 4'h3;
  localparam logic [4:0] MSB_IDX = 5'h11;
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_RESULT = 4'h8;
  localparam int CFG_TEN = 0;
  localparam int CFG_BIP = 1;
  localparam int CFG_WARP = 2;
  localparam int CFG_IMP = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int STS_BUSY = 0;
  localparam int STS_PWR = 1;
  localparam int STS_STALE = 2;
  localparam int STS_MODE = 4;
  localparam int STS_RANGE = 6;
  localparam int STS_SW = 8;
  localparam logic [1:0] SERIAL_IF_SEL = 2'h3;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_WARP = 2'b01, MODE_IMPULSE = 2'b10
  } smc_mode_t;
  typedef enum logic [1:0] {
    ST_ACQ = 2'b00, ST_READY = 2'b01, ST_WAKE = 2'b10, ST_TRIAL = 2'b11
  } smc_state_t;
endpackage : smc_pkg
`default_nettype wire

// ---- design/smc_ctrl.sv ----
// Purpose: Conversion sequencing and mode selection of an 18-bit SAR converter.
// Assumes: All pins synchronous to clk_sys_in; compare_in valid each trial.
// Notes: Registers sit behind an Avalon-MM slave with one wait state.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`default_nettype none
// Functional notes
// - Conversion starts after acquisition ends and a start falling edge.
// - Each sample resolves to 18 bits, one binary trial per bit.
// - Trials go from MSB down to LSB, one per bit.
// - After the last trial the code is formed and busy drops.
// - The result belongs to the sample of that same start.
// - Fast select high, low-power low gives the fastest mode.
// - Both selects equal gives normal mode without idle limit.
// - Fast low, low-power high gives low-power mode.
// - Low-power mode sleeps after each conversion and wakes for the next.
// - Range and mode may change at any time, four ranges, three modes.
// - A new setting applies after one acquisition, no reset needed.
// - In serial software mode settings come from the configuration register.
// - Mode and range pins are ignored while the register supplies settings.
// - Register source only when interface select is 3 and source low.
module smc_ctrl import smc_pkg::*; #(
  parameter int CAL_IDLE_LIMIT = CAL_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Conversion pins
  input wire logic convert_start_n_in,
  input wire logic warp_sel_in,
  input wire logic impulse_sel_in,
  input wire logic bipolar_sel_in,
  input wire logic ten_sel_in,
  input wire logic [1:0] if_mode_sel_in,
  input wire logic config_source_sel_in,
  // Comparator and converter core
  input wire logic compare_in,
  output logic busy_out,
  output logic track_out,
  output logic [17:0] trial_code_out,
  output logic [17:0] result_out,
  output logic powerdown_out,
  output logic [1:0] mode_out,
  output logic [1:0] range_out
);

  function automatic smc_mode_t mode_decode(input logic warp, input logic imp);
    if (warp == imp) begin
      return MODE_NORMAL;
    end else if (warp) begin
      return MODE_WARP;
    end
    return MODE_IMPULSE;
  endfunction : mode_decode

  function automatic logic [3:0] step_len(input smc_mode_t m);
    logic [3:0] r;
    r = STEP_NORMAL;
    unique case (m)
      MODE_WARP: r = STEP_WARP;
      MODE_NORMAL: r = STEP_NORMAL;
      MODE_IMPULSE: r = STEP_IMPULSE;
      default: r = STEP_NORMAL;
    endcase
    return r;
  endfunction : step_len

  smc_state_t state_reg, state_next;
  smc_mode_t mode_reg, mode_next, cfg_mode, pin_mode, sel_mode;
  logic [3:0] cnt_reg, cnt_next;
  logic [4:0] bit_reg, bit_next;
  logic [17:0] sar_reg, sar_next, result_reg, result_next, trial;
  logic [1:0] range_reg, range_next, sel_range;
  logic [15:0] idle_reg, idle_next;
  logic busy_reg, busy_next, pwr_reg, pwr_next, stale_reg, stale_next;
  logic start_n_reg, sw_cfg, start_go, step_end;
  logic [3:0] cfg_reg, cfg_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next, status;

  // Setting source and selection
  assign sw_cfg = (if_mode_sel_in == SERIAL_IF_SEL) && !config_source_sel_in;
  assign cfg_mode = mode_decode(cfg_reg[CFG_WARP], cfg_reg[CFG_IMP]);
  assign pin_mode = mode_decode(warp_sel_in, impulse_sel_in);
  // Mode and range pins are not looked at in serial software mode
  assign sel_mode = sw_cfg ? cfg_mode : pin_mode;
  assign sel_range = sw_cfg ? {cfg_reg[CFG_BIP], cfg_reg[CFG_TEN]}
                            : {bipolar_sel_in, ten_sel_in};
  assign start_go = (state_reg == ST_READY) && start_n_reg
                    && !convert_start_n_in;
  assign trial = sar_reg | (18'h1 << bit_reg);
  assign step_end = (cnt_reg == 4'h1);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sar_next = sar_reg;
    result_next = result_reg;
    busy_next = busy_reg;
    pwr_next = pwr_reg;
    stale_next = stale_reg;
    mode_next = mode_reg;
    range_next = range_reg;
    idle_next = (idle_reg == 16'hffff) ? idle_reg : idle_reg + 16'h1;
    unique case (state_reg)
      ST_ACQ: begin
        cnt_next = cnt_reg - 4'h1;
        if (step_end) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        // Edges that come during acquisition or busy are simply lost
        if (start_go) begin
          busy_next = 1'b1;
          // Settings are caught here, so a change needs one acquisition
          mode_next = sel_mode;
          range_next = sel_range;
          sar_next = 18'h0;
          bit_next = MSB_IDX;
          // Flags a warp result taken after a long idle gap
          stale_next = (sel_mode == MODE_WARP)
                       && (int'(idle_reg) > CAL_IDLE_LIMIT);
          idle_next = 16'h0;
          if (pwr_reg) begin
            state_next = ST_TRIAL;
            cnt_next = step_len(sel_mode);
          end else begin
            state_next = ST_WAKE;
            cnt_next = WAKE_CYCLES;
          end
        end
      end
      ST_WAKE: begin
        cnt_next = cnt_reg - 4'h1;
        if (step_end) begin
          pwr_next = 1'b1;
          state_next = ST_TRIAL;
          cnt_next = step_len(mode_reg);
        end
      end
      ST_TRIAL: begin
        cnt_next = cnt_reg - 4'h1;
        if (step_end) begin
          sar_next = compare_in ? trial : sar_reg;
          if (bit_reg == 5'h0) begin
            result_next = compare_in ? trial : sar_reg;
            busy_next = 1'b0;
            state_next = ST_ACQ;
            cnt_next = ACQ_CYCLES;
            if (mode_reg == MODE_IMPULSE) begin
              pwr_next = 1'b0;
            end
          end else begin
            bit_next = bit_reg - 5'h1;
            cnt_next = step_len(mode_reg);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_ACQ;
      cnt_reg <= ACQ_CYCLES;
      bit_reg <= MSB_IDX;
      sar_reg <= 18'h0;
      result_reg <= 18'h0;
      busy_reg <= 1'b0;
      pwr_reg <= 1'b1;
      stale_reg <= 1'b0;
      mode_reg <= MODE_NORMAL;
      range_reg <= 2'h0;
      idle_reg <= 16'h0;
      start_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sar_reg <= sar_next;
      result_reg <= result_next;
      busy_reg <= busy_next;
      pwr_reg <= pwr_next;
      stale_reg <= stale_next;
      mode_reg <= mode_next;
      range_reg <= range_next;
      idle_reg <= idle_next;
      start_n_reg <= convert_start_n_in;
    end
  end

  // Register slave: every access takes exactly one wait state
  always_comb begin
    status = 32'h0;
    status[STS_BUSY] = busy_reg;
    status[STS_PWR] = pwr_reg;
    status[STS_STALE] = stale_reg;
    status[STS_MODE +: 2] = mode_reg;
    status[STS_RANGE +: 2] = range_reg;
    status[STS_SW] = sw_cfg;
    ack_next = (avs_read_in || avs_write_in) && !ack_reg;
    rdata_next = rdata_reg;
    cfg_next = cfg_reg;
    if (avs_read_in && !ack_reg) begin
      unique case (avs_address_in)
        OFS_CONFIG: rdata_next = {28'h0, cfg_reg};
        OFS_STATUS: rdata_next = status;
        OFS_RESULT: rdata_next = {14'h0, result_reg};
        default: rdata_next = 32'h0;
      endcase
    end
    if (avs_write_in && ack_reg && (avs_address_in == OFS_CONFIG)
        && avs_byteenable_in[0]) begin
      cfg_next = avs_writedata_in[3:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
      cfg_reg <= CFG_RESET;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
    end
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
  assign avs_readdata_out = rdata_reg;
  assign busy_out = busy_reg;
  assign track_out = (state_reg == ST_ACQ) || (state_reg == ST_READY);
  assign trial_code_out = trial;
  assign result_out = result_reg;
  assign powerdown_out = !pwr_reg;
  assign mode_out = mode_reg;
  assign range_out = range_reg;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  start_gate_a: assert property ($rose(busy_reg) |->
    $past(state_reg) == ST_READY && !$past(convert_start_n_in))
    else $error("busy rose without a start after acquisition");
  busy_hold_a: assert property (start_go |=> busy_reg [*8])
    else $error("busy not held after start");
  msb_first_a: assert property ($rose(busy_reg) |->
    bit_reg == MSB_IDX && sar_reg == 18'h0)
    else $error("conversion did not begin at the msb");
  bit_step_a: assert property ((state_reg == ST_TRIAL && step_end
    && bit_reg != 5'h0) |=> bit_reg == $past(bit_reg) - 5'h1)
    else $error("trial index did not step by one");
  done_a: assert property ((state_reg == ST_TRIAL && step_end
    && bit_reg == 5'h0) |=> !busy_reg && state_reg == ST_ACQ)
    else $error("busy not dropped after last trial");
  result_a: assert property ($fell(busy_reg) |-> result_reg == sar_reg)
    else $error("result does not match this conversion");
  warp_sel_a: assert property ((start_go && !sw_cfg && warp_sel_in
    && !impulse_sel_in) |=> mode_reg == MODE_WARP)
    else $error("warp mode not selected");
  normal_sel_a: assert property ((start_go && !sw_cfg
    && warp_sel_in == impulse_sel_in) |=> mode_reg == MODE_NORMAL)
    else $error("normal mode not selected");
  impulse_sel_a: assert property ((start_go && !sw_cfg && !warp_sel_in
    && impulse_sel_in) |=> mode_reg == MODE_IMPULSE)
    else $error("impulse mode not selected");
  sleep_wake_a: assert property ((start_go && !pwr_reg) |=>
    !pwr_reg ##[1:11] pwr_reg)
    else $error("core did not wake in time");
  setting_take_a: assert property (start_go |=>
    range_reg == $past(sel_range) && mode_reg == $past(sel_mode))
    else $error("setting not taken at start");
  acq_after_a: assert property ($fell(busy_reg) |->
    (state_reg == ST_ACQ) [*8])
    else $error("acquisition cut short");
  soft_cfg_a: assert property ((start_go && sw_cfg) |=>
    mode_reg == $past(cfg_mode))
    else $error("register setting not used");
  bus_answer_a: assert property ((avs_read_in || avs_write_in) |->
    ##[0:1] !avs_waitrequest_out)
    else $error("bus access not answered");

  warp_done_c: cover property (mode_reg == MODE_WARP && $fell(busy_reg));
  impulse_wake_c: cover property (state_reg == ST_WAKE ##1 state_reg == ST_TRIAL);
  soft_cfg_c: cover property (start_go && sw_cfg);
  cfg_write_c: cover property (avs_write_in && !avs_waitrequest_out);

endmodule : smc_ctrl
`default_nettype wire

// ---- test/smc_cmp_model.sv ----
// Purpose: Comparator and track-and-hold seen by the conversion control.
// Assumes: Level is held at the last cycle that tracking was active.
// Notes: Answers at once, combinational from the trial code.
`default_nettype none
module smc_cmp_model (
  // Clock
  input wire logic clk_in,
  // Core side
  input wire logic track_in,
  input wire logic [17:0] trial_in,
  input wire logic [17:0] level_in,
  output logic compare_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] held_reg;
  // Sample freezes when tracking stops at the start edge
  always_ff @(posedge clk_in) begin
    if (track_in) begin
      held_reg <= level_in;
    end
  end
  assign compare_out = held_reg >= trial_in;
endmodule : smc_cmp_model
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the SAR conversion control.
// Assumes: Short calibration idle limit of 100 cycles.
// Notes: Driver queues expected results; a monitor checks them at busy fall.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;
  typedef struct {logic [17:0] r; int len; logic [1:0] m; logic [1:0] g;} smc_exp_t;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic start_n = 1'b1;
  logic warp = 1'b0;
  logic imp = 1'b0;
  logic bip = 1'b0;
  logic ten = 1'b0;
  logic [1:0] ifm = 2'h0;
  logic src = 1'b1;
  logic cmp;
  logic busy_out;
  logic powerdown_out;
  logic track_out;
  logic [17:0] trial;
  logic [17:0] result_out;
  logic [1:0] mode_out;
  logic [1:0] range_out;
  logic [17:0] level = 18'h0;
  logic [31:0] seed = 32'h27;
  logic pd = 1'b0;
  logic bprev = 1'b0;
  int blen = 0;
  int cyc = 0;
  int err_total = 0;
  int n_checks = 0;
  smc_exp_t exp_q[$];
  smc_ctrl #(.CAL_IDLE_LIMIT(100)) u_smc_ctrl (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .convert_start_n_in(start_n), .warp_sel_in(warp), .impulse_sel_in(imp),
    .bipolar_sel_in(bip), .ten_sel_in(ten), .if_mode_sel_in(ifm),
    .config_source_sel_in(src), .compare_in(cmp), .busy_out(busy_out),
    .track_out(track_out), .trial_code_out(trial), .result_out(result_out),
    .powerdown_out(powerdown_out), .mode_out(mode_out), .range_out(range_out));
  smc_cmp_model u_smc_cmp_model (.clk_in(clk_sys_in), .track_in(track_out),
    .trial_in(trial), .level_in(level), .compare_out(cmp));
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Register reads are their own kind of result
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    chk(g, e);
  endtask : chk_reg
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // Request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    // Values read right after the edge are those the slave showed at it
    do begin
      @(posedge clk_sys_in);
    end while (wait_req);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic conv(input logic [1:0] m, input logic [1:0] g);
    smc_exp_t e;
    do @(negedge clk_sys_in); while (busy_out);
    repeat (14) @(posedge clk_sys_in);
    seed = lfsr(seed);
    level <= seed[17:0];
    e.r = seed[17:0];
    e.len = 18 * int'((m == 2'h1) ? STEP_WARP : (m == 2'h2) ? STEP_IMPULSE : STEP_NORMAL)
            + (pd ? int'(WAKE_CYCLES) : 0);
    e.m = m;
    e.g = g;
    pd = (m == 2'h2);
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    start_n <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    start_n <= 1'b1;
    // A second falling edge while busy must not start anything
    @(posedge clk_sys_in);
    start_n <= 1'b0;
    @(posedge clk_sys_in);
    start_n <= 1'b1;
  endtask : conv
  always @(posedge clk_sys_in) begin
    smc_exp_t e;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
    bprev <= busy_out;
    if (busy_out) blen <= blen + 1;
    if (bprev && !busy_out) begin
      blen <= 0;
      if (exp_q.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        chk(32'(result_out), 32'(e.r));
        chk(32'(blen), 32'(e.len));
        chk(32'(mode_out), 32'(e.m));
        chk(32'(range_out), 32'(e.g));
        chk(32'(powerdown_out), 32'(e.m == 2'h2));
      end
    end
  end
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      warp <= i[0];
      imp <= i[1];
      bip <= i[2];
      ten <= i[0];
      conv((i[0] && !i[1]) ? 2'h1 : (!i[0] && i[1]) ? 2'h2 : 2'h0, {i[2], i[0]});
    end
    ifm <= 2'h3;
    src <= 1'b0;
    warp <= 1'b1;
    imp <= 1'b0;
    bip <= 1'b0;
    ten <= 1'b0;
    bus(1'b1, OFS_CONFIG, 32'hf, q);
    bus(1'b0, OFS_CONFIG, 32'h0, q);
    chk_reg(q, 32'hf);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk_reg(32'(q[STS_SW]), 32'h1);
    bus(1'b0, 4'hc, 32'h0, q);
    chk_reg(q, 32'h0);
    conv(2'h0, 2'h3);
    src <= 1'b1;
    conv(2'h1, 2'h0);
    repeat (150) @(posedge clk_sys_in);
    conv(2'h1, 2'h0);
    do @(negedge clk_sys_in); while (busy_out);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk_reg(32'(q[STS_STALE]), 32'h1);
    repeat (4) @(posedge clk_sys_in);
    chk(32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
